// ---- hw/ccr_regs.svh ----
// Operation
// RULE_01: Rise enable set: rising result edge sets flag
// RULE_02: Fall enable set: falling result edge sets flag
// RULE_03: Negative codes 000-011 route negative pins 0-3
// RULE_04: Negative 110 reference buffer two, 111 ground
// RULE_05: Negative codes 100, 101 leave input open
// RULE_06: Positive 000 routes pin 0, 001 pin 1
// RULE_07: Positive code 101 routes converter output
// RULE_08: Positive 110 reference buffer two, 111 ground
// RULE_09: Positive codes 010, 011, 100 leave input open
// RULE_10: Mirror bit 1 copies comparator 2, read-only
// RULE_11: Mirror bit 0 copies comparator 1, read-only
// RULE_12: Upper unimplemented bits ignore writes, read zero
// RULE_13: Enables and selects reset to zero, read/write
// RULE_14: Mirror bits read-only, zero after any reset
// RULE_15: Sync option: output updates on timer falling edge
// RULE_16: Edges detected on synchronised result, flag sticky
// RULE_17: Both enables set: any change sets flag
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_A_EDGE1 8'h00
`define CCR_A_NSEL1 8'h04
`define CCR_A_PSEL1 8'h08
`define CCR_A_EDGE2 8'h0c
`define CCR_A_NSEL2 8'h10
`define CCR_A_PSEL2 8'h14
`define CCR_A_MIRROR 8'h18
`define CCR_A_STATUS 8'h1c
`define CCR_A_MASK 8'h20
`define CCR_CH_STRIDE 8'h0c
`define CCR_B_FALL 0
`define CCR_B_RISE 1
`define CCR_ZERO2 2'h0
`define CCR_ZERO3 3'h0
`define CCR_ZERO32 32'h0
`define CCR_SEL_N0 3'h0
`define CCR_SEL_N1 3'h1
`define CCR_SEL_N2 3'h2
`define CCR_SEL_N3 3'h3
`define CCR_SEL_REF 3'h6
`define CCR_SEL_GND 3'h7
`define CCR_SEL_DAC 3'h5
// Negative route one-hot: pins 0..3, reference, ground
`define CCR_NR_REF 4
`define CCR_NR_GND 5
// Positive route one-hot: pins 0..1, converter, reference, ground
`define CCR_PR_DAC 2
`define CCR_PR_REF 3
`define CCR_PR_GND 4
`endif

// ---- hw/ccr_pkg.sv ----
package ccr_pkg;
  typedef struct packed {
    logic sel;
    logic [7:0] addr;
    logic [1:0] trans;
    logic write;
    logic ready;
    logic [31:0] wdata;
  } ccr_ahb_in_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic readyout;
    logic resp;
  } ccr_ahb_out_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic tclk_prev;
    logic [1:0] out;
    logic [1:0][1:0] edge_en;
    logic [1:0][2:0] nsel;
    logic [1:0][2:0] psel;
    logic [1:0][5:0] nroute;
    logic [1:0][4:0] proute;
    logic [1:0] flag;
    logic [1:0] mask;
    logic irq;
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    ccr_ahb_out_t bus;
  } ccr_state_t;
endpackage

// ---- hw/ccr_top.sv ----
`timescale 1ns/1ps
`include "ccr_regs.svh"
module ccr_top (
  input wire logic mclk_i, // System clock, 20 MHz
  input wire logic rst_n_i, // Synchronous reset
  input wire logic hsel_i, // Slave select
  input wire logic [31:0] haddr_i, // Byte address
  input wire logic [1:0] htrans_i, // Transfer type
  input wire logic hwrite_i, // Write when high
  input wire logic [2:0] hsize_i, // Word only
  input wire logic [31:0] hwdata_i, // Write data
  input wire logic hready_i, // Bus ready
  output logic [31:0] hrdata_o, // Read data
  output logic hreadyout_o, // Slave ready
  output logic hresp_o, // Always OKAY
  input wire logic [1:0] cmp_result_i, // Raw comparator results
  input wire logic [1:0] sync_en_i, // Per comparator sync option
  input wire logic tmr_clk_i, // Timer clock source, sampled
  output logic [1:0] cmp_out_o, // Result to timer and pin
  output logic [1:0][5:0] neg_route_o, // Inverting input switches
  output logic [1:0][4:0] pos_route_o, // Non-inverting input switches
  output logic [1:0] cmp_irq_flag_o, // Sticky edge flags
  output logic irq_o // Unmasked flag pending
);
  ccr_pkg::ccr_state_t q_reg;
  ccr_pkg::ccr_state_t q_next;
  ccr_pkg::ccr_ahb_in_t bin;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] hit;
  logic take;
  logic tfall;
  logic [7:0] off;
  logic [31:0] rd;

  assign bin.sel = hsel_i;
  assign bin.addr = haddr_i[7:0];
  assign bin.trans = htrans_i;
  assign bin.write = hwrite_i;
  assign bin.ready = hready_i;
  assign bin.wdata = hwdata_i;

  always_comb
  begin
    q_next = q_reg;
    // Two flops before anything looks at the raw analog result
    q_next.sync1 = cmp_result_i;
    q_next.sync2 = q_reg.sync1;
    q_next.prev = q_reg.sync2;
    q_next.tclk_prev = tmr_clk_i;
    tfall = q_reg.tclk_prev & ~tmr_clk_i;
    rise = q_reg.sync2 & ~q_reg.prev; // see RULE_16
    fall = ~q_reg.sync2 & q_reg.prev; // see RULE_16
    for (int i = 0; i < 2; i++)
    begin
      hit[i] = (rise[i] & q_reg.edge_en[i][`CCR_B_RISE]) // see RULE_01, RULE_17
        | (fall[i] & q_reg.edge_en[i][`CCR_B_FALL]); // see RULE_02, RULE_17
      // Synced path adds latency but keeps the pin glitch-free
      if (!sync_en_i[i] || tfall)
        q_next.out[i] = q_reg.sync2[i]; // see RULE_15
      q_next.nroute[i] = '0;
      unique case (q_reg.nsel[i])
        `CCR_SEL_N0, `CCR_SEL_N1, `CCR_SEL_N2, `CCR_SEL_N3:
          q_next.nroute[i][q_reg.nsel[i][1:0]] = 1'b1; // see RULE_03
        `CCR_SEL_REF: q_next.nroute[i][`CCR_NR_REF] = 1'b1; // see RULE_04
        `CCR_SEL_GND: q_next.nroute[i][`CCR_NR_GND] = 1'b1; // see RULE_04
        default: q_next.nroute[i] = '0; // see RULE_05
      endcase
      q_next.proute[i] = '0;
      unique case (q_reg.psel[i])
        `CCR_SEL_N0, `CCR_SEL_N1:
          q_next.proute[i][q_reg.psel[i][0]] = 1'b1; // see RULE_06
        `CCR_SEL_DAC: q_next.proute[i][`CCR_PR_DAC] = 1'b1; // see RULE_07
        `CCR_SEL_REF: q_next.proute[i][`CCR_PR_REF] = 1'b1; // see RULE_08
        `CCR_SEL_GND: q_next.proute[i][`CCR_PR_GND] = 1'b1; // see RULE_08
        default: q_next.proute[i] = '0; // see RULE_09
      endcase
    end
    // Bus: one wait state so a read never races a write
    take = bin.sel & bin.trans[1] & bin.ready;
    q_next.dph = take;
    q_next.dwr = take & bin.write;
    q_next.daddr = take ? bin.addr : q_reg.daddr;
    q_next.bus.readyout = ~take;
    q_next.bus.resp = 1'b0;
    off = q_reg.daddr;
    rd = `CCR_ZERO32;
    for (int i = 0; i < 2; i++)
    begin
      if (off == `CCR_A_EDGE1 + 8'(i) * `CCR_CH_STRIDE)
        rd = {30'h0, q_reg.edge_en[i]}; // see RULE_12
      if (off == `CCR_A_NSEL1 + 8'(i) * `CCR_CH_STRIDE)
        rd = {29'h0, q_reg.nsel[i]};
      if (off == `CCR_A_PSEL1 + 8'(i) * `CCR_CH_STRIDE)
        rd = {29'h0, q_reg.psel[i]};
    end
    if (off == `CCR_A_MIRROR)
      rd = {30'h0, q_reg.sync2}; // see RULE_10, RULE_11, RULE_14
    if (off == `CCR_A_STATUS)
      rd = {30'h0, q_reg.flag};
    if (off == `CCR_A_MASK)
      rd = {30'h0, q_reg.mask};
    q_next.bus.rdata = (q_reg.dph && !q_reg.dwr) ? rd : `CCR_ZERO32;
    // Set wins over write-one-to-clear
    q_next.flag = q_reg.flag | hit; // see RULE_16
    if (q_reg.dwr)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (off == `CCR_A_EDGE1 + 8'(i) * `CCR_CH_STRIDE)
          q_next.edge_en[i] = bin.wdata[1:0]; // see RULE_13
        if (off == `CCR_A_NSEL1 + 8'(i) * `CCR_CH_STRIDE)
          q_next.nsel[i] = bin.wdata[2:0]; // see RULE_13
        if (off == `CCR_A_PSEL1 + 8'(i) * `CCR_CH_STRIDE)
          q_next.psel[i] = bin.wdata[2:0]; // see RULE_13
      end
      if (off == `CCR_A_STATUS)
        q_next.flag = (q_reg.flag & ~bin.wdata[1:0]) | hit;
      if (off == `CCR_A_MASK)
        q_next.mask = bin.wdata[1:0];
    end
    q_next.irq = |(q_next.flag & q_next.mask);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q_reg <= '0; // see RULE_13, RULE_14
      q_reg.bus.readyout <= 1'b1;
    end
    else
      q_reg <= q_next;
  end

  assign hrdata_o = q_reg.bus.rdata;
  assign hreadyout_o = q_reg.bus.readyout;
  assign hresp_o = q_reg.bus.resp;
  assign cmp_out_o = q_reg.out;
  assign neg_route_o = q_reg.nroute;
  assign pos_route_o = q_reg.proute;
  assign cmp_irq_flag_o = q_reg.flag;
  assign irq_o = q_reg.irq;

  AST_RISE_SETS: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_01
    (q_reg.sync2[0] && !q_reg.prev[0] && q_reg.edge_en[0][`CCR_B_RISE]) |=> q_reg.flag[0])
    else $error("rising edge did not set flag 0");
  AST_FALL_SETS: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_02
    (!q_reg.sync2[1] && q_reg.prev[1] && q_reg.edge_en[1][`CCR_B_FALL]) |=> q_reg.flag[1])
    else $error("falling edge did not set flag 1");
  AST_NO_EDGE_NO_SET: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
    (!q_reg.flag[0] && (q_reg.sync2[0] == q_reg.prev[0])) |=> !q_reg.flag[0])
    else $error("flag 0 set without an edge");
  AST_NEG_PIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
    (q_reg.nsel[0] == `CCR_SEL_N3) ##1 $stable(q_reg.nsel[0])
      |-> q_reg.nroute[0] == 6'h08)
    else $error("negative pin 3 not routed");
  AST_NEG_OPEN: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_05
    (q_reg.nsel[1][2:1] == 2'h2) ##1 $stable(q_reg.nsel[1]) |-> q_reg.nroute[1] == 6'h00)
    else $error("negative input not left open");
  AST_POS_DAC: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_07
    (q_reg.psel[0] == `CCR_SEL_DAC) ##1 $stable(q_reg.psel[0])
      |-> q_reg.proute[0] == 5'h04)
    else $error("converter not routed");
  AST_POS_GND: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_08
    (q_reg.psel[1] == `CCR_SEL_GND) ##1 $stable(q_reg.psel[1])
      |-> q_reg.proute[1] == 5'h10)
    else $error("ground not routed");
  AST_MIRROR_READ: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_10
    (q_reg.dph && !q_reg.dwr && q_reg.daddr == `CCR_A_MIRROR)
      |=> hrdata_o == {30'h0, $past(q_reg.sync2)})
    else $error("mirror read mismatch");
  AST_SYNC_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_15
    (sync_en_i[0] && !(q_reg.tclk_prev && !tmr_clk_i)) |=> $stable(q_reg.out[0]))
    else $error("synced output moved without timer falling edge");
  AST_WAIT_STATE: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
    (hsel_i && htrans_i[1] && hready_i) |=> !hreadyout_o ##1 hreadyout_o)
    else $error("bus wait state wrong");

  // Reset checks run without disable so the reset branch itself is covered
  AST_RESET_CTRL: assert property (@(posedge mclk_i) // see RULE_13
    !rst_n_i
    |=> q_reg.edge_en == '0 && q_reg.nsel == '0 && q_reg.psel == '0)
    else $error("control fields not cleared by reset");
  AST_RESET_MIRROR: assert property (@(posedge mclk_i) // see RULE_14
    !rst_n_i
    |=> q_reg.sync2 == 2'h0 && cmp_irq_flag_o == 2'h0 && hreadyout_o)
    else $error("mirror or flags not cleared by reset");
  AST_RESP_OKAY: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
    hreadyout_o
    |-> !hresp_o)
    else $error("response not okay");
  AST_UPPER_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
    hreadyout_o
    |-> hrdata_o[31:3] == 29'h0)
    else $error("upper read bits not zero");
  AST_RDATA_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
    !(q_reg.dph && !q_reg.dwr)
    |=> hrdata_o == 32'h0)
    else $error("read data outside a read");
  AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
    irq_o == |(cmp_irq_flag_o & q_reg.mask))
    else $error("interrupt level wrong");

  // Per comparator checks; both channels share one register layout
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chk
    localparam logic [7:0] edge_addr = `CCR_A_EDGE1 + 8'(ch) * `CCR_CH_STRIDE;
    localparam logic [7:0] nsel_addr = `CCR_A_NSEL1 + 8'(ch) * `CCR_CH_STRIDE;
    localparam logic [7:0] psel_addr = `CCR_A_PSEL1 + 8'(ch) * `CCR_CH_STRIDE;

    AST_N_PIN0: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      q_reg.nsel[ch] == `CCR_SEL_N0
      |=> q_reg.nroute[ch] == 6'h01)
      else $error("negative code 0 misrouted");
    AST_N_PIN1: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      q_reg.nsel[ch] == `CCR_SEL_N1
      |=> q_reg.nroute[ch] == 6'h02)
      else $error("negative code 1 misrouted");
    AST_N_PIN2: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      q_reg.nsel[ch] == `CCR_SEL_N2
      |=> q_reg.nroute[ch] == 6'h04)
      else $error("negative code 2 misrouted");
    AST_N_PIN3: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      q_reg.nsel[ch] == `CCR_SEL_N3
      |=> q_reg.nroute[ch] == 6'h08)
      else $error("negative code 3 misrouted");
    AST_N_OPEN4: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_05
      q_reg.nsel[ch] == 3'h4
      |=> q_reg.nroute[ch] == 6'h00)
      else $error("negative code 4 not open");
    AST_N_OPEN5: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_05
      q_reg.nsel[ch] == 3'h5
      |=> q_reg.nroute[ch] == 6'h00)
      else $error("negative code 5 not open");
    AST_N_REF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_04
      q_reg.nsel[ch] == `CCR_SEL_REF
      |=> q_reg.nroute[ch] == 6'h10)
      else $error("negative reference misrouted");
    AST_N_GND: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_04
      q_reg.nsel[ch] == `CCR_SEL_GND
      |=> q_reg.nroute[ch] == 6'h20)
      else $error("negative ground misrouted");
    AST_N_ONEHOT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_03
      $onehot0(q_reg.nroute[ch]))
      else $error("two negative sources at once");

    AST_P_PIN0: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_06
      q_reg.psel[ch] == `CCR_SEL_N0
      |=> q_reg.proute[ch] == 5'h01)
      else $error("positive code 0 misrouted");
    AST_P_PIN1: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_06
      q_reg.psel[ch] == `CCR_SEL_N1
      |=> q_reg.proute[ch] == 5'h02)
      else $error("positive code 1 misrouted");
    AST_P_OPEN2: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_09
      q_reg.psel[ch] == 3'h2
      |=> q_reg.proute[ch] == 5'h00)
      else $error("positive code 2 not open");
    AST_P_OPEN3: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_09
      q_reg.psel[ch] == 3'h3
      |=> q_reg.proute[ch] == 5'h00)
      else $error("positive code 3 not open");
    AST_P_OPEN4: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_09
      q_reg.psel[ch] == 3'h4
      |=> q_reg.proute[ch] == 5'h00)
      else $error("positive code 4 not open");
    AST_P_DAC: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_07
      q_reg.psel[ch] == `CCR_SEL_DAC
      |=> q_reg.proute[ch] == 5'h04)
      else $error("positive converter misrouted");
    AST_P_REF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_08
      q_reg.psel[ch] == `CCR_SEL_REF
      |=> q_reg.proute[ch] == 5'h08)
      else $error("positive reference misrouted");
    AST_P_GND: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_08
      q_reg.psel[ch] == `CCR_SEL_GND
      |=> q_reg.proute[ch] == 5'h10)
      else $error("positive ground misrouted");
    AST_P_ONEHOT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_06
      $onehot0(q_reg.proute[ch]))
      else $error("two positive sources at once");

    AST_RISE_ON: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_01
      q_reg.sync2[ch] && !q_reg.prev[ch] && q_reg.edge_en[ch][`CCR_B_RISE]
      |=> q_reg.flag[ch])
      else $error("enabled rise did not set flag");
    AST_FALL_ON: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_02
      !q_reg.sync2[ch] && q_reg.prev[ch] && q_reg.edge_en[ch][`CCR_B_FALL]
      |=> q_reg.flag[ch])
      else $error("enabled fall did not set flag");
    AST_RISE_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_01
      !q_reg.flag[ch] && q_reg.sync2[ch] && !q_reg.prev[ch]
      && !q_reg.edge_en[ch][`CCR_B_RISE]
      |=> !q_reg.flag[ch])
      else $error("disabled rise set flag");
    AST_FALL_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_02
      !q_reg.flag[ch] && !q_reg.sync2[ch] && q_reg.prev[ch]
      && !q_reg.edge_en[ch][`CCR_B_FALL]
      |=> !q_reg.flag[ch])
      else $error("disabled fall set flag");
    AST_ANY_EDGE: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_17
      q_reg.edge_en[ch] == 2'h3 && q_reg.sync2[ch] != q_reg.prev[ch]
      |=> q_reg.flag[ch])
      else $error("change with both enables missed");
    AST_FLAG_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
      q_reg.flag[ch] && !(q_reg.dwr && q_reg.daddr == `CCR_A_STATUS)
      |=> q_reg.flag[ch])
      else $error("flag dropped without a clear");
    AST_FLAG_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
      q_reg.dwr && q_reg.daddr == `CCR_A_STATUS && hwdata_i[ch] && !hit[ch]
      |=> !q_reg.flag[ch])
      else $error("write one did not clear flag");
    AST_SET_WINS: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
      q_reg.dwr && q_reg.daddr == `CCR_A_STATUS && hwdata_i[ch] && hit[ch]
      |=> q_reg.flag[ch])
      else $error("clear beat a new edge");
    AST_PREV_FOLLOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_16
      q_reg.sync2[ch] != q_reg.prev[ch]
      |=> q_reg.prev[ch] == $past(q_reg.sync2[ch]))
      else $error("edge history stage stuck");

    AST_OUT_DIRECT: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_15
      !sync_en_i[ch]
      |=> cmp_out_o[ch] == $past(q_reg.sync2[ch]))
      else $error("direct output does not follow");
    AST_OUT_SYNC: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_15
      sync_en_i[ch] && q_reg.tclk_prev && !tmr_clk_i
      |=> cmp_out_o[ch] == $past(q_reg.sync2[ch]))
      else $error("synced output missed timer fall");
    AST_OUT_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_15
      sync_en_i[ch] && !(q_reg.tclk_prev && !tmr_clk_i)
      |=> $stable(cmp_out_o[ch]))
      else $error("synced output moved early");

    AST_EDGE_WR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      q_reg.dwr && q_reg.daddr == edge_addr
      |=> q_reg.edge_en[ch] == $past(hwdata_i[1:0]))
      else $error("edge enable write lost");
    AST_NSEL_WR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      q_reg.dwr && q_reg.daddr == nsel_addr
      |=> q_reg.nsel[ch] == $past(hwdata_i[2:0]))
      else $error("negative select write lost");
    AST_PSEL_WR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      q_reg.dwr && q_reg.daddr == psel_addr
      |=> q_reg.psel[ch] == $past(hwdata_i[2:0]))
      else $error("positive select write lost");
    AST_EDGE_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      !(q_reg.dwr && q_reg.daddr == edge_addr)
      |=> $stable(q_reg.edge_en[ch]))
      else $error("edge enable changed unasked");
    AST_NSEL_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      !(q_reg.dwr && q_reg.daddr == nsel_addr)
      |=> $stable(q_reg.nsel[ch]))
      else $error("negative select changed unasked");
    AST_PSEL_KEEP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_13
      !(q_reg.dwr && q_reg.daddr == psel_addr)
      |=> $stable(q_reg.psel[ch]))
      else $error("positive select changed unasked");

    AST_EDGE_RD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
      q_reg.dph && !q_reg.dwr && q_reg.daddr == edge_addr
      |=> hrdata_o == {30'h0, $past(q_reg.edge_en[ch])})
      else $error("edge enable read wrong");
    AST_NSEL_RD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
      q_reg.dph && !q_reg.dwr && q_reg.daddr == nsel_addr
      |=> hrdata_o == {29'h0, $past(q_reg.nsel[ch])})
      else $error("negative select read wrong");
    AST_PSEL_RD: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // see RULE_12
      q_reg.dph && !q_reg.dwr && q_reg.daddr == psel_addr
      |=> hrdata_o == {29'h0, $past(q_reg.psel[ch])})
      else $error("positive select read wrong");
  end
endmodule

// ---- bench/ccr_tb.sv ----
`timescale 1ns/1ps
`include "ccr_regs.svh"
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      err_count++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [1:0] cmp_result_i = 2'h0;
  logic [1:0] sync_en_i = 2'h0;
  logic tmr_clk_i = 1'b0;
  logic [31:0] hrdata_o, w, exp_now;
  logic hreadyout_o, hresp_o, irq_o;
  logic rd_pend = 1'b0;
  logic [1:0] cmp_out_o, cmp_irq_flag_o, f, m;
  logic [1:0][5:0] neg_route_o;
  logic [1:0][4:0] pos_route_o;
  logic [7:0] b;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h73bd1f06;
  ccr_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .cmp_result_i(cmp_result_i), .sync_en_i(sync_en_i),
    .tmr_clk_i(tmr_clk_i), .cmp_out_o(cmp_out_o), .neg_route_o(neg_route_o),
    .pos_route_o(pos_route_o), .cmp_irq_flag_o(cmp_irq_flag_o), .irq_o(irq_o));
  initial
  forever #25 mclk_i = ~mclk_i;
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      results();
    end
  end
  always @(posedge mclk_i)
  begin
    if (rd_pend && hreadyout_o === 1'b1)
    begin
      exp_now = exp_q.pop_front();
      `CHK("hrdata", exp_now, hrdata_o)
      `CHK("hresp", 1'b0, hresp_o)
      rd_pend <= 1'b0;
    end
    if (hsel_i && htrans_i[1] && hreadyout_o && !hwrite_i) rd_pend <= 1'b1;
  end
  task automatic wait_rdy();
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= wr ? d : 32'h0;
    wait_rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask
  function automatic logic [5:0] nexp(input logic [2:0] k);
    case (k)
      3'h6: nexp = 6'h10;
      3'h7: nexp = 6'h20;
      3'h4, 3'h5: nexp = 6'h00;
      default: nexp = 6'h01 << k;
    endcase
  endfunction
  function automatic logic [4:0] pexp(input logic [2:0] k);
    case (k)
      3'h0: pexp = 5'h01;
      3'h1: pexp = 5'h02;
      3'h5: pexp = 5'h04;
      3'h6: pexp = 5'h08;
      3'h7: pexp = 5'h10;
      default: pexp = 5'h00;
    endcase
  endfunction
  initial
  begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int a = 0; a <= 36; a += 4) rd(8'(a), 32'h0);
    $display("test reset values done");
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 8; k++)
      begin
        b = 8'(c) * `CCR_CH_STRIDE;
        w = $random(seed);
        xfer(`CCR_A_NSEL1 + b, 1'b1, {w[31:3], 3'(k)});
        xfer(`CCR_A_PSEL1 + b, 1'b1, {w[31:3], 3'(7 - k)});
        rd(`CCR_A_NSEL1 + b, 32'(k));
        rd(`CCR_A_PSEL1 + b, 32'(7 - k));
        `CHK("neg_route", nexp(3'(k)), neg_route_o[c])
        `CHK("pos_route", pexp(3'(7 - k)), pos_route_o[c])
      end
    $display("test input selects done");
    for (int c = 0; c < 2; c++)
      for (int e = 0; e < 4; e++)
      begin
        b = 8'(c) * `CCR_CH_STRIDE;
        w = $random(seed);
        m = w[1:0];
        xfer(`CCR_A_EDGE1 + b, 1'b1, {w[31:2], 2'(e)});
        xfer(`CCR_A_MASK, 1'b1, w);
        cmp_result_i[c] <= 1'b1;
        repeat (8) @(posedge mclk_i);
        f = 2'(e >> 1) << c;
        `CHK("rise_flag", f, cmp_irq_flag_o)
        `CHK("irq", |(f & m), irq_o)
        rd(`CCR_A_EDGE1 + b, 32'(e));
        xfer(`CCR_A_MIRROR, 1'b1, 32'hff);
        rd(`CCR_A_MIRROR, {30'h0, cmp_result_i});
        xfer(`CCR_A_STATUS, 1'b1, 32'h3);
        cmp_result_i[c] <= 1'b0;
        repeat (8) @(posedge mclk_i);
        f = 2'(e & 1) << c;
        `CHK("fall_flag", f, cmp_irq_flag_o)
        rd(`CCR_A_STATUS, {30'h0, f});
        xfer(`CCR_A_STATUS, 1'b1, 32'h3);
      end
    $display("test edge flags done");
    sync_en_i <= 2'h3;
    tmr_clk_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    cmp_result_i <= 2'h3;
    repeat (8) @(posedge mclk_i);
    `CHK("cmp_out_held", 2'h0, cmp_out_o)
    tmr_clk_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    `CHK("cmp_out_synced", 2'h3, cmp_out_o)
    sync_en_i <= 2'h0;
    cmp_result_i <= 2'h1;
    repeat (6) @(posedge mclk_i);
    `CHK("cmp_out_direct", 2'h1, cmp_out_o)
    $display("test output sync done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(`CCR_A_NSEL2, 32'h0);
    rd(`CCR_A_EDGE1, 32'h0);
    `CHK("flag_after_reset", 2'h0, cmp_irq_flag_o)
    $display("test second reset done");
    repeat (2) @(posedge mclk_i);
    results();
  end
endmodule
